// ### rtl/vr_ctrl_pkg.sv
// constants shared by the phase mode and target slew controller
// assumes a single 125 MHz clock and APB register access
package vr_ctrl_pkg;
    // register byte offsets
    localparam logic [7:0] MAIN_CMD_OFS   = 8'h00;
    localparam logic [7:0] AUX_CMD_OFS    = 8'h04;
    localparam logic [7:0] PSTATE_OFS     = 8'h08;
    localparam logic [7:0] STATUS_OFS     = 8'h0C;
    localparam logic [7:0] IRQ_STAT_OFS   = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h14;

    // command register fields
    localparam int CMD_TARGET_LSB = 0;
    localparam int CMD_RATE_LSB   = 8;
    localparam int VID_W          = 8;

    // target rate codes
    localparam logic [1:0] RATE_QUICK  = 2'h0;
    localparam logic [1:0] RATE_GENTLE = 2'h1;
    localparam logic [1:0] RATE_COAST  = 2'h2;

    // power state register fields
    localparam int PS_MAIN_LSB = 0;
    localparam int PS_AUX_LSB  = 2;

    // status register fields
    localparam int ST_CFG_LSB      = 0;
    localparam int ST_AUX_OFF      = 2;
    localparam int ST_CFG_VALID    = 3;
    localparam int ST_BUSY_LSB     = 4;
    localparam int ST_COAST_LSB    = 6;
    localparam int ST_MAIN_VID_LSB = 8;
    localparam int ST_AUX_VID_LSB  = 16;

    // irq status bits
    localparam int IRQ_MAIN_DONE   = 0;
    localparam int IRQ_AUX_DONE    = 1;
    localparam int IRQ_AUX_BLOCKED = 2;
    localparam int IRQ_W           = 3;

    // main rail phase configuration codes
    localparam logic [1:0] CFG_4PH = 2'h0;
    localparam logic [1:0] CFG_3PH = 2'h1;
    localparam logic [1:0] CFG_2PH = 2'h2;
    localparam logic [1:0] CFG_1PH = 2'h3;

    // timing
    localparam int CLK_PERIOD_PS        = 8000;
    localparam int VID_STEP_UV          = 5000;
    localparam int QUICK_RATE_UV_PER_US = 10000;
    localparam int GENTLE_RATE_UV_PER_US = 2500;
    localparam int QUICK_STEP_NS  = VID_STEP_UV * 1000 / QUICK_RATE_UV_PER_US;
    localparam int GENTLE_STEP_NS = VID_STEP_UV * 1000 / GENTLE_RATE_UV_PER_US;
    // a minimum rate means a longest step time: round down
    localparam int QUICK_STEP_CYC  = QUICK_STEP_NS * 1000 / CLK_PERIOD_PS;
    localparam int GENTLE_STEP_CYC = GENTLE_STEP_NS * 1000 / CLK_PERIOD_PS;
    localparam int STRAP_SETTLE_CYC = 4;

    typedef enum logic [1:0] {RAIL_IDLE, RAIL_RAMP, RAIL_COAST} rail_state_e;
endpackage

// ### rtl/vr_phase_slew_ctrl.sv
// phase mode selection and target voltage slew control for a two-rail regulator
// assumes APB master on clk, strap and decay pins asynchronous to clk
// Overview of operation
// - phase-4 strap high alone gives three-phase main rail, phases 1-3.
// - phase-4 and phase-3 straps high give two-phase main rail, phases 1-2.
// - phase-4, phase-3 and phase-2 sense straps high give single-phase main rail.
// - four-phase: PS0 four-phase CONTINUOUS_INDUCTOR_MODE, PS1 two-phase CONTINUOUS_INDUCTOR_MODE, PS2/3 one-phase skip.
// - three-phase: PS0 three-phase CONTINUOUS_INDUCTOR_MODE, PS1 two-phase CONTINUOUS_INDUCTOR_MODE, PS2/3 one-phase skip.
// - two-phase: PS0/1 two-phase CONTINUOUS_INDUCTOR_MODE, PS2/3 one-phase pulse skip.
// - single-phase: PS0/1 one-phase CONTINUOUS_INDUCTOR_MODE, PS2/3 one-phase pulse skip.
// - aux rail single-phase: PS0/1 continuous, PS2/3 pulse skip.
// - aux sum-negative strap high disables aux rail and blocks its commands.
// - both rails slew identically toward each new target at the selected rate.
// - target command chooses quick, gentle or coast rate.
// - quick/gentle force CONTINUOUS_INDUCTOR_MODE and ramp at least 10 or 2.5 mV/us.
// - coast to a lower target forces pulse skip and output falls passively with the load; coast to a target at or above the code leaves the rail idle.
// - coasting descent is clamped to the gentle rate.
// - attention goes low when quick/gentle transition completes, never after coast.
// - quick/gentle upward command during coast abandons coast, ramps, then signals.
`timescale 1ns/100ps
module vr_phase_slew_ctrl #(
    parameter int QUICK_CYC  = vr_ctrl_pkg::QUICK_STEP_CYC,
    parameter int GENTLE_CYC = vr_ctrl_pkg::GENTLE_STEP_CYC
) (
    input  wire logic        clk,                  // 125 MHz clock
    input  wire logic        rstn,                 // async reset, active low
    input  wire logic [7:0]  paddr,                // apb address
    input  wire logic        psel,                 // apb select
    input  wire logic        penable,              // apb enable
    input  wire logic        pwrite,               // apb direction
    input  wire logic [31:0] pwdata,               // apb write data
    output logic      [31:0] prdata,               // apb read data
    output logic             pready,               // apb ready
    output logic             pslverr,              // apb error
    input  wire logic        phase4_drive_out,     // phase-4 pin level, strap sense
    input  wire logic        phase3_drive_out,     // phase-3 pin level, strap sense
    input  wire logic        phase2_current_sense, // phase-2 sense pin level, strap sense
    input  wire logic        aux_current_sum_neg,  // aux sum-negative pin level, strap sense
    input  wire logic [1:0]  load_fall_step,       // per rail: output fell one step (async)
    output logic      [3:0]  main_phase_enable,    // main rail active phases
    output logic             main_continuous_inductor_mode, // main rail CONTINUOUS_INDUCTOR_MODE, else pulse skip
    output logic             aux_rail_enable,      // aux rail running
    output logic             aux_continuous_inductor_mode,  // aux rail CONTINUOUS_INDUCTOR_MODE, else pulse skip
    output logic      [7:0]  main_vid,             // main rail reference code
    output logic      [7:0]  aux_vid,              // aux rail reference code
    output logic             alert_n,              // attention, active low
    output logic             irq                   // level interrupt
);
    localparam int NR = 2;

    initial begin
        if (QUICK_CYC < 1 || GENTLE_CYC < 1 || QUICK_CYC > 255 || GENTLE_CYC > 255)
            $error("step cycle counts must lie in 1..255");
    end

    // strap synchronisers and one-shot capture
    logic [3:0] strap_meta;
    logic [3:0] strap_sync;
    logic [2:0] settle_cnt;
    logic       cfg_valid;
    logic [1:0] cfg;
    logic       aux_off;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_meta <= 4'h0;
            strap_sync <= 4'h0;
        end else begin
            strap_meta <= {aux_current_sum_neg, phase2_current_sense, phase3_drive_out, phase4_drive_out};
            strap_sync <= strap_meta;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            settle_cnt <= 3'h0;
            cfg_valid  <= 1'b0;
            cfg        <= vr_ctrl_pkg::CFG_4PH;
            aux_off    <= 1'b0;
        end else if (!cfg_valid) begin
            if (settle_cnt == 3'(vr_ctrl_pkg::STRAP_SETTLE_CYC - 1)) begin
                cfg_valid <= 1'b1;
                aux_off   <= strap_sync[3];
                if (strap_sync[0] && strap_sync[1] && strap_sync[2])
                    cfg <= vr_ctrl_pkg::CFG_1PH;
                else if (strap_sync[0] && strap_sync[1])
                    cfg <= vr_ctrl_pkg::CFG_2PH;
                else if (strap_sync[0])
                    cfg <= vr_ctrl_pkg::CFG_3PH;
                else
                    cfg <= vr_ctrl_pkg::CFG_4PH;
            end else begin
                settle_cnt <= settle_cnt + 3'h1;
            end
        end
    end

    // decay step pins: two flops then edge detect on the second
    logic [NR-1:0] fall_meta;
    logic [NR-1:0] fall_sync;
    logic [NR-1:0] fall_prev;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fall_meta <= '0;
            fall_sync <= '0;
            fall_prev <= '0;
        end else begin
            fall_meta <= load_fall_step;
            fall_sync <= fall_meta;
            fall_prev <= fall_sync;
        end
    end

    // apb slave: fixed one-cycle access phase
    localparam int IRQ_W_L = vr_ctrl_pkg::IRQ_W;
    localparam int VW = vr_ctrl_pkg::VID_W;
    localparam int DONE_BITS = 1 << vr_ctrl_pkg::IRQ_MAIN_DONE | 1 << vr_ctrl_pkg::IRQ_AUX_DONE;
    logic                wr_acc;
    logic [1:0]          ps_main;
    logic [1:0]          ps_aux;
    logic [IRQ_W_L-1:0]  irq_stat;
    logic [IRQ_W_L-1:0]  irq_mask;
    logic [NR-1:0]       cmd_go;
    logic [NR-1:0]       done_ev;
    logic                blocked_ev;
    logic [VW-1:0]       cmd_target;
    logic [1:0]          cmd_rate;
    logic [VW-1:0]       vid [NR];
    logic [NR-1:0]       busy;
    logic [NR-1:0]       coasting;
    logic                addr_ok;
    logic [31:0]         rd_val;
    logic                rate_ok;

    assign wr_acc     = psel && penable && pready && pwrite;
    assign cmd_target = pwdata[vr_ctrl_pkg::CMD_TARGET_LSB +: VW];
    assign cmd_rate   = pwdata[vr_ctrl_pkg::CMD_RATE_LSB +: 2];
    assign rate_ok    = cmd_rate != 2'h3;

    always_comb begin
        addr_ok = 1'b1;
        rd_val  = 32'h0;
        case (paddr)
            vr_ctrl_pkg::MAIN_CMD_OFS: rd_val[VW-1:0] = vid[0];
            vr_ctrl_pkg::AUX_CMD_OFS:  rd_val[VW-1:0] = vid[1];
            vr_ctrl_pkg::PSTATE_OFS: begin
                rd_val[vr_ctrl_pkg::PS_MAIN_LSB +: 2] = ps_main;
                rd_val[vr_ctrl_pkg::PS_AUX_LSB +: 2]  = ps_aux;
            end
            vr_ctrl_pkg::STATUS_OFS: begin
                rd_val[vr_ctrl_pkg::ST_CFG_LSB +: 2]       = cfg;
                rd_val[vr_ctrl_pkg::ST_AUX_OFF]            = aux_off;
                rd_val[vr_ctrl_pkg::ST_CFG_VALID]          = cfg_valid;
                rd_val[vr_ctrl_pkg::ST_BUSY_LSB +: NR]     = busy;
                rd_val[vr_ctrl_pkg::ST_COAST_LSB +: NR]    = coasting;
                rd_val[vr_ctrl_pkg::ST_MAIN_VID_LSB +: VW] = vid[0];
                rd_val[vr_ctrl_pkg::ST_AUX_VID_LSB +: VW]  = vid[1];
            end
            vr_ctrl_pkg::IRQ_STAT_OFS: rd_val[IRQ_W_L-1:0] = irq_stat;
            vr_ctrl_pkg::IRQ_MASK_OFS: rd_val[IRQ_W_L-1:0] = irq_mask;
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && !penable;
            prdata  <= (psel && !penable && !pwrite) ? rd_val : 32'h0;
            // blocked aux commands and bad rate codes are refused with an error
            pslverr <= psel && !penable && (!addr_ok || (pwrite && (
                       (paddr == vr_ctrl_pkg::AUX_CMD_OFS && (aux_off || !cfg_valid || !rate_ok)) ||
                       (paddr == vr_ctrl_pkg::MAIN_CMD_OFS && (!cfg_valid || !rate_ok)))));
        end
    end

    // command launches
    always_comb begin
        cmd_go     = '0;
        blocked_ev = 1'b0;
        if (wr_acc && !pslverr) begin
            if (paddr == vr_ctrl_pkg::MAIN_CMD_OFS)
                cmd_go[0] = 1'b1;
            if (paddr == vr_ctrl_pkg::AUX_CMD_OFS)
                cmd_go[1] = 1'b1;
        end
        if (wr_acc && paddr == vr_ctrl_pkg::AUX_CMD_OFS && aux_off)
            blocked_ev = 1'b1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ps_main  <= 2'h0;
            ps_aux   <= 2'h0;
            irq_mask <= '0;
        end else if (wr_acc) begin
            if (paddr == vr_ctrl_pkg::PSTATE_OFS) begin
                ps_main <= pwdata[vr_ctrl_pkg::PS_MAIN_LSB +: 2];
                if (!aux_off)
                    ps_aux <= pwdata[vr_ctrl_pkg::PS_AUX_LSB +: 2];
            end
            if (paddr == vr_ctrl_pkg::IRQ_MASK_OFS)
                irq_mask <= pwdata[IRQ_W_L-1:0];
        end
    end

    // sticky events; a set in the clearing cycle wins
    logic [IRQ_W_L-1:0] irq_set;
    logic [IRQ_W_L-1:0] irq_clr;
    assign irq_set = {blocked_ev, done_ev};
    assign irq_clr = (wr_acc && paddr == vr_ctrl_pkg::IRQ_STAT_OFS) ? pwdata[IRQ_W_L-1:0] : '0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            irq_stat <= '0;
        else
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq     <= 1'b0;
            alert_n <= 1'b1;
        end else begin
            irq     <= |((irq_stat & ~irq_clr | irq_set) & irq_mask);
            // attention holds low until software clears the completion bits
            alert_n <= !(|((irq_stat & ~irq_clr | irq_set) & IRQ_W_L'(DONE_BITS)));
        end
    end

    // per-rail slew engine
    genvar r;
    generate
        for (r = 0; r < NR; r++) begin : g_rail
            vr_ctrl_pkg::rail_state_e state;
            logic [VW-1:0] target;
            logic [7:0]    step_cnt;
            logic [7:0]    step_len;
            logic          fall_pend;

            assign busy[r]     = state != vr_ctrl_pkg::RAIL_IDLE;
            assign coasting[r] = state == vr_ctrl_pkg::RAIL_COAST;

            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    state     <= vr_ctrl_pkg::RAIL_IDLE;
                    target    <= '0;
                    vid[r]    <= '0;
                    step_cnt  <= 8'h0;
                    step_len  <= 8'h0;
                    fall_pend <= 1'b0;
                    done_ev[r] <= 1'b0;
                end else begin
                    done_ev[r] <= 1'b0;
                    if (step_cnt != 8'h0)
                        step_cnt <= step_cnt - 8'h1;
                    if (fall_sync[r] && !fall_prev[r])
                        fall_pend <= 1'b1;
                    if (cmd_go[r]) begin
                        // a new command always takes over, abandoning any coast
                        target   <= cmd_target;
                        step_cnt <= 8'h0;
                        fall_pend <= 1'b0;
                        case (cmd_rate)
                            vr_ctrl_pkg::RATE_QUICK: begin
                                state    <= vr_ctrl_pkg::RAIL_RAMP;
                                step_len <= 8'(QUICK_CYC);
                            end
                            vr_ctrl_pkg::RATE_GENTLE: begin
                                state    <= vr_ctrl_pkg::RAIL_RAMP;
                                step_len <= 8'(GENTLE_CYC);
                            end
                            default: begin
                                state    <= (cmd_target < vid[r]) ? vr_ctrl_pkg::RAIL_COAST
                                                                  : vr_ctrl_pkg::RAIL_IDLE;
                                step_len <= 8'(GENTLE_CYC);
                            end
                        endcase
                    end else begin
                        case (state)
                            vr_ctrl_pkg::RAIL_RAMP: begin
                                if (vid[r] == target) begin
                                    state      <= vr_ctrl_pkg::RAIL_IDLE;
                                    done_ev[r] <= 1'b1;
                                end else if (step_cnt == 8'h0) begin
                                    vid[r]   <= (vid[r] < target) ? vid[r] + 1'b1 : vid[r] - 1'b1;
                                    step_cnt <= step_len - 8'h1;
                                end
                            end
                            vr_ctrl_pkg::RAIL_COAST: begin
                                // load-driven fall, never faster than the gentle step
                                if (vid[r] <= target) begin
                                    state <= vr_ctrl_pkg::RAIL_IDLE;
                                end else if (fall_pend && step_cnt == 8'h0) begin
                                    vid[r]    <= vid[r] - 1'b1;
                                    fall_pend <= 1'b0;
                                    step_cnt  <= step_len - 8'h1;
                                end
                            end
                            default: state <= vr_ctrl_pkg::RAIL_IDLE;
                        endcase
                    end
                end
            end
        end
    endgenerate

    // phase count and conduction mode per power state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            main_phase_enable             <= 4'h0;
            main_continuous_inductor_mode <= 1'b0;
            main_vid                      <= 8'h00;
        end else begin
            main_vid <= vid[0];
            if (!cfg_valid) begin
                main_phase_enable             <= 4'h0;
                main_continuous_inductor_mode <= 1'b0;
            end else if (ps_main[1] || coasting[0]) begin
                main_phase_enable             <= 4'h1;
                main_continuous_inductor_mode <= busy[0] && !coasting[0];
            end else begin
                main_continuous_inductor_mode <= 1'b1;
                case (cfg)
                    vr_ctrl_pkg::CFG_4PH: main_phase_enable <= ps_main[0] ? 4'h3 : 4'hF;
                    vr_ctrl_pkg::CFG_3PH: main_phase_enable <= ps_main[0] ? 4'h3 : 4'h7;
                    vr_ctrl_pkg::CFG_2PH: main_phase_enable <= 4'h3;
                    default:              main_phase_enable <= 4'h1;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aux_rail_enable              <= 1'b0;
            aux_continuous_inductor_mode <= 1'b0;
            aux_vid                      <= 8'h00;
        end else begin
            aux_vid         <= vid[1];
            aux_rail_enable <= cfg_valid && !aux_off;
            if (coasting[1])
                aux_continuous_inductor_mode <= 1'b0;
            else
                aux_continuous_inductor_mode <= cfg_valid && !aux_off
                                                && (!ps_aux[1] || busy[1]);
        end
    end
endmodule

// ### verif/vr_phase_slew_ctrl_sva.sv
// port assertions for the phase mode and target slew controller
// assumes one clk domain and rstn async active low; bound below
`timescale 1ns/100ps
module vr_phase_slew_ctrl_sva #(
    parameter int QUICK_CYC  = 62,
    parameter int GENTLE_CYC = 250
) (
    input wire logic        clk,                           // clock
    input wire logic        rstn,                          // reset, active low
    input wire logic [7:0]  paddr,                         // apb address
    input wire logic        psel,                          // apb select
    input wire logic        penable,                       // apb enable
    input wire logic        pwrite,                        // apb direction
    input wire logic [31:0] pwdata,                        // apb write data
    input wire logic        pready,                        // apb ready
    input wire logic        pslverr,                       // apb error
    input wire logic [3:0]  main_phase_enable,             // main phases
    input wire logic        main_continuous_inductor_mode, // main ccm
    input wire logic        aux_rail_enable,               // aux running
    input wire logic        aux_continuous_inductor_mode,  // aux ccm
    input wire logic [7:0]  main_vid,                      // main code
    input wire logic [7:0]  aux_vid,                       // aux code
    input wire logic        alert_n                        // attention
);
    logic [7:0] tgt;
    logic       pend;
    wire        commit = psel && penable && pready && pwrite && !pslverr && paddr == vr_ctrl_pkg::MAIN_CMD_OFS;

    // pending quick or gentle target, dropped once attention is seen
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tgt  <= 8'h00;
            pend <= 1'b0;
        end else if (commit) begin
            tgt  <= pwdata[7:0];
            pend <= pwdata[9:8] < 2'h2;
        end else if (!alert_n) begin
            pend <= 1'b0;
        end
    end

    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_target_met;
        pend && main_vid == tgt;
    endsequence
    sequence s_alert_soon;
        ##[1:4] !alert_n;
    endsequence

    a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not a single access cycle");
    a_skip_single: assert property (!main_continuous_inductor_mode && main_phase_enable != 4'h0 |-> main_phase_enable == 4'h1)
        else $error("pulse skip with more than one phase");
    a_vid_unit: assert property ($changed(main_vid) |-> 8'(main_vid - $past(main_vid)) inside {8'h01, 8'hFF})
        else $error("main code moved by more than one step");
    a_step_gap: assert property ($changed(main_vid) |=> $stable(main_vid))
        else $error("main code stepped on adjacent cycles");
    a_ramp_ccm: assert property (main_vid > $past(main_vid) |-> $past(main_continuous_inductor_mode))
        else $error("upward step without continuous mode");
    a_done_alert: assert property (s_target_met |-> s_alert_soon)
        else $error("no attention after target reached");
    a_aux_frozen: assert property (!aux_rail_enable |=> $stable(aux_vid))
        else $error("aux code moved while aux disabled");
    a_aux_ccm_gate: assert property (aux_continuous_inductor_mode |-> aux_rail_enable)
        else $error("aux continuous mode while disabled");
endmodule

bind vr_phase_slew_ctrl vr_phase_slew_ctrl_sva #(.QUICK_CYC(QUICK_CYC), .GENTLE_CYC(GENTLE_CYC)) u_sva (
    .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .main_phase_enable(main_phase_enable),
    .main_continuous_inductor_mode(main_continuous_inductor_mode), .aux_rail_enable(aux_rail_enable),
    .aux_continuous_inductor_mode(aux_continuous_inductor_mode), .main_vid(main_vid), .aux_vid(aux_vid),
    .alert_n(alert_n));

// ### verif/vr_load_model.sv
// load at the rail outputs: a rising fall bit is one step down
// assumes the bench enables sinking only while a rail coasts
`timescale 1ns/100ps
module vr_load_model (
    input  wire logic       clk,           // bench clock
    input  wire logic [1:0] sink_on,       // per rail: load pulls down
    output logic      [1:0] load_fall_step // per rail: step fallen
);
    initial load_fall_step = 2'h0;
    // heavy load, one fall every other cycle: faster than the gentle clamp
    always @(posedge clk) load_fall_step <= sink_on & ~load_fall_step;
endmodule

// ### verif/vr_phase_slew_ctrl_test.sv
// self-checking bench for the phase mode and target slew controller
// assumes short step counts and the load model on the fall inputs
`timescale 1ns/100ps
module vr_phase_slew_ctrl_test;
    localparam int QC = 2;
    localparam int GC = 4;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  strap = 4'h0;
    logic [1:0]  sink_on = 2'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, mccm, aon, accm, alert_n, irq;
    logic [1:0]  fall;
    logic [3:0]  mph;
    logic [7:0]  mvid, avid;
    int          num_errors = 0;
    int          n_tests = 0;

    always #4 clk = ~clk;

    vr_phase_slew_ctrl #(.QUICK_CYC(QC), .GENTLE_CYC(GC)) u_dut (
        .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase4_drive_out(strap[0]), .phase3_drive_out(strap[1]), .phase2_current_sense(strap[2]),
        .aux_current_sum_neg(strap[3]), .load_fall_step(fall), .main_phase_enable(mph),
        .main_continuous_inductor_mode(mccm), .aux_rail_enable(aon), .aux_continuous_inductor_mode(accm),
        .main_vid(mvid), .aux_vid(avid), .alert_n(alert_n), .irq(irq));
    vr_load_model u_load (.clk(clk), .sink_on(sink_on), .load_fall_step(fall));

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(1, 0);
    endtask

    task automatic boot(input logic [3:0] s);
        @(posedge clk);
        rstn  <= 1'b0;
        strap <= s;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        tick(10);
    endtask

    function automatic logic [3:0] exp_ph(input logic [1:0] c, input logic [1:0] ps);
        return ps[1] ? 4'h1 : ps[0] ? (c == 2'h3 ? 4'h1 : 4'h3) : 4'hF >> c;
    endfunction

    task automatic t_modes(input logic [1:0] c);
        boot({1'b0, c == 2'h3, c >= 2'h2, c != 2'h0});
        apb(1'b0, vr_ctrl_pkg::STATUS_OFS, 32'h0);
        chk(rd[3:0], {2'b10, c});
        for (int ps = 0; ps < 4; ps++) begin
            apb(1'b1, vr_ctrl_pkg::PSTATE_OFS, {28'h0, 2'(ps), 2'(ps)});
            tick(3);
            chk({mph, mccm, aon, accm}, {exp_ph(c, 2'(ps)), ps < 2, 1'b1, ps < 2});
        end
        @(posedge clk);
        strap <= ~strap;
        tick(8);
        apb(1'b0, vr_ctrl_pkg::STATUS_OFS, 32'h0);
        chk({mph, aon, rd[3:0]}, {4'h1, 1'b1, 2'b10, c});
    endtask

    task automatic t_ramp(input logic [7:0] a, input logic [1:0] r, input logic [7:0] from, input logic [7:0] to);
        int n;
        n = 0;
        apb(1'b1, a, {22'h0, r, to});
        while (alert_n !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        chk(a[2] ? avid : mvid, to);
        chk(n <= (to - from) * (r[0] ? GC : QC) + 6, 1);
        chk(irq, 0);
        apb(1'b0, vr_ctrl_pkg::IRQ_STAT_OFS, 32'h0);
        chk(rd, 32'h1 << a[2]);
        apb(1'b1, vr_ctrl_pkg::IRQ_MASK_OFS, 32'h1 << a[2]);
        tick(2);
        chk(irq, 1);
        apb(1'b1, vr_ctrl_pkg::IRQ_STAT_OFS, 32'h7);
        tick(2);
        chk({alert_n, irq}, 2'b10);
        apb(1'b1, vr_ctrl_pkg::IRQ_MASK_OFS, 32'h0);
    endtask

    task automatic t_coast;
        int   n;
        logic bad;
        n = 0;
        bad = 1'b0;
        apb(1'b1, vr_ctrl_pkg::MAIN_CMD_OFS, 32'h0202);
        sink_on <= 2'h1;
        tick(2);
        while (mvid !== 8'h02 && n < 100) begin
            if (mvid > 8'h03) bad |= (alert_n !== 1'b1) || (mccm !== 1'b0) || (mph !== 4'h1);
            tick(1);
            n++;
        end
        chk(bad, 0);
        chk(n >= 2 * GC + 3, 1);
        apb(1'b0, vr_ctrl_pkg::IRQ_STAT_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, vr_ctrl_pkg::MAIN_CMD_OFS, 32'h0200);
        n = 0;
        while (mvid !== 8'h01 && n < 100) begin
            tick(1);
            n++;
        end
        apb(1'b1, vr_ctrl_pkg::MAIN_CMD_OFS, 32'h0004);
        sink_on <= 2'h0;
        n = 0;
        while (alert_n !== 1'b0 && n < 100) begin
            tick(1);
            n++;
        end
        chk({alert_n, mvid}, {1'b0, 8'h04});
        apb(1'b1, vr_ctrl_pkg::IRQ_STAT_OFS, 32'h7);
    endtask

    task automatic t_refuse;
        apb(1'b1, vr_ctrl_pkg::MAIN_CMD_OFS, 32'h0309);
        chk({er, mvid}, {1'b1, 8'h04});
        apb(1'b0, 8'h18, 32'h0);
        chk(er, 1);
        boot(4'h8);
        apb(1'b1, vr_ctrl_pkg::AUX_CMD_OFS, 32'h0001);
        chk(er, 1);
        apb(1'b0, vr_ctrl_pkg::IRQ_STAT_OFS, 32'h0);
        chk({rd[2:0], aon, avid}, {3'b100, 1'b0, 8'h00});
    endtask

    task automatic tally_and_finish;
        if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        num_errors++;
        tally_and_finish;
    end

    initial begin
        for (int c = 0; c < 4; c++) t_modes(2'(c));
        boot(4'h0);
        t_ramp(vr_ctrl_pkg::MAIN_CMD_OFS, vr_ctrl_pkg::RATE_QUICK, 8'h00, 8'h05);
        t_ramp(vr_ctrl_pkg::AUX_CMD_OFS, vr_ctrl_pkg::RATE_GENTLE, 8'h00, 8'h03);
        t_coast;
        t_refuse;
        tally_and_finish;
    end
endmodule
